// File: shared/pwm_pkg.sv
// Constants, register map and field layouts of the triple 11-bit PWM generator.
`default_nettype none
package pwm_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets (APB, one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CLOCK_SELECT_PRESCALE = 8'h00;
    localparam logic [7:0] OFF_UPPER_BOUND_HIGH      = 8'h04;
    localparam logic [7:0] OFF_UPPER_BOUND_LOW       = 8'h08;
    localparam logic [7:0] OFF_CHAN_BASE             = 8'h0c;  // Duty high of channel zero.
    localparam logic [7:0] OFF_CHAN_STRIDE           = 8'h0c;  // Distance between channel groups.
    localparam logic [7:0] OFF_DUTY_LOW_REL          = 8'h04;  // Duty low, from the group base.
    localparam logic [7:0] OFF_CTRL_REL              = 8'h08;  // Channel control, from the group base.
    localparam logic [7:0] OFF_STATUS                = 8'h30;  // Read-only counter position.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_REG8  = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CLK_EN_BIT  = 7;  // Counter run enable.
    localparam int CLK_PRE_LSB = 4;  // Prescaler code, three bits.
    localparam int CLK_SRC_BIT = 0;  // 1: fast RC clock, 0: system clock.
    localparam int LOW_DB_LSB  = 6;  // Two low bits of a bound.
    localparam int LOW_HALF    = 5;  // Half-step duty bit.
    localparam logic [7:0] CTRL_WR_MASK = 8'hf7;  // Bit 3 is reserved.

    // Combining modes of channel zero with channel one.
    localparam logic [1:0] COMB_NONE = 2'h0;
    localparam logic [1:0] COMB_OR   = 2'h1;
    localparam logic [1:0] COMB_XOR  = 2'h2;

    typedef struct packed {
        logic       en;    // Route the channel to its pin.
        logic       inv;   // Invert the channel output.
        logic [1:0] comb;  // Combining mode, channel zero only.
        logic       rsvd;  // Reads as zero.
        logic [2:0] pin;   // Index into the channel's pin list.
    } chan_ctrl_t;

    // ------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------
    localparam int NUM_PINS = 13;
    localparam logic [3:0] PIN_PA0  = 4'h0;
    localparam logic [3:0] PIN_PB4  = 4'h1;
    localparam logic [3:0] PIN_PB5  = 4'h2;
    localparam logic [3:0] PIN_PC2  = 4'h3;
    localparam logic [3:0] PIN_PB6  = 4'h4;
    localparam logic [3:0] PIN_PA4  = 4'h5;
    localparam logic [3:0] PIN_PB7  = 4'h6;
    localparam logic [3:0] PIN_PC3  = 4'h7;
    localparam logic [3:0] PIN_PA3  = 4'h8;
    localparam logic [3:0] PIN_PB2  = 4'h9;
    localparam logic [3:0] PIN_PB3  = 4'ha;
    localparam logic [3:0] PIN_PA5  = 4'hb;  // Open drain only.
    localparam logic [3:0] PIN_PC0  = 4'hc;
    localparam logic [3:0] PIN_NONE = 4'hf;

endpackage
`default_nettype wire

// File: hdl/triple_pwm.sv
// Triple 11-bit PWM generator with shared time base, APB registers and pin routing.
//
// The address map and the APB slave port were left to the implementer.
`default_nettype none

// What this block does
// - One shared up-counter and clock selector time all three channels together.
// - Software picks the fast RC clock or the system clock for the counter.
// - Frequency is source clock over prescaler (1..128) over counter bound plus one.
// - Counter bound is upper-bound high bits then upper-bound low bits 7:6.
// - Duty bound is duty high then duty low 7:6; duty low bit 5 adds a half step when the prescaler divides by more than one.
// - High time is (duty bound + half step/2 + 1/2) over (counter bound + 1); with a divide of one it is (duty bound + 1) over (counter bound + 1).
// - Each period is high for the duty part and low for the rest.
// - Each channel drives the pin chosen from its own candidate list.
// - Channel zero gets the shared pin only when channel one has not chosen it.
// - Channel two gets the shared pin only when channel zero has not chosen it.
// - Channel two drives its open-drain candidate pin only as open drain.
// - Channel zero can OR or XOR its waveform with channel one's.
// - Complementary pair is channel two plus inverted channel zero XOR one.
// - With the gating option on, the comparator result gates the waveforms.
// - Each channel control has an inverse bit that inverts its output.
module triple_pwm
(
    input  wire logic                        pclk,                      // APB clock, 125 MHz.
    input  wire logic                        presetn,                   // Asynchronous reset, low.
    input  wire logic                        psel,                      // APB select.
    input  wire logic                        penable,                   // APB access phase.
    input  wire logic                        pwrite,                    // APB write.
    input  wire logic [7:0]                  paddr,                     // APB byte address.
    input  wire logic [31:0]                 pwdata,                    // APB write data.
    output logic                             pready,                    // APB ready, always high.
    output logic [31:0]                      prdata,                    // APB read data.
    output logic                             pslverr,                   // Unmapped address.
    input  wire logic                        internal_fast_rc_clock,    // Fast RC tick, one pclk wide.
    input  wire logic                        comparator_gating_option,  // Build option level.
    input  wire logic                        comparator_result,         // Comparator output.
    output logic [pwm_pkg::NUM_PINS-1:0]     pin_out,                   // Pin output levels.
    output logic [pwm_pkg::NUM_PINS-1:0]     pin_oe                     // Pin output enables.
);

    // ------------------------------------------------------------------
    // Pin lists
    // ------------------------------------------------------------------

    // Maps a channel and its pin code to a pin index; used for all three channels.
    function automatic logic [3:0] chan_pin(input logic [1:0] ch, input logic [2:0] sel);
        logic [3:0] p;
        p = pwm_pkg::PIN_NONE;
        if (ch == 2'h0)
        begin
            case (sel)
                3'h0: p = pwm_pkg::PIN_PA0;
                3'h1: p = pwm_pkg::PIN_PB4;
                3'h2: p = pwm_pkg::PIN_PB5;
                3'h3: p = pwm_pkg::PIN_PC2;
                3'h4: p = pwm_pkg::PIN_PB6;
                default: p = pwm_pkg::PIN_NONE;
            endcase
        end
        else if (ch == 2'h1)
        begin
            case (sel)
                3'h0: p = pwm_pkg::PIN_PA4;
                3'h1: p = pwm_pkg::PIN_PB6;
                3'h2: p = pwm_pkg::PIN_PB7;
                3'h3: p = pwm_pkg::PIN_PC3;
                default: p = pwm_pkg::PIN_NONE;
            endcase
        end
        else
        begin
            case (sel)
                3'h0: p = pwm_pkg::PIN_PA3;
                3'h1: p = pwm_pkg::PIN_PB2;
                3'h2: p = pwm_pkg::PIN_PB3;
                3'h3: p = pwm_pkg::PIN_PA5;
                3'h4: p = pwm_pkg::PIN_PC0;
                3'h5: p = pwm_pkg::PIN_PB5;
                default: p = pwm_pkg::PIN_NONE;
            endcase
        end
        return p;
    endfunction

    // ------------------------------------------------------------------
    // Registers and APB decode
    // ------------------------------------------------------------------
    logic [7:0]          clk_cfg_q;
    logic [7:0]          ubh_q;
    logic [7:0]          ubl_q;
    logic [7:0]          dth_q [0:2];
    logic [7:0]          dtl_q [0:2];
    pwm_pkg::chan_ctrl_t ctl_q [0:2];
    logic [31:0]         rdata_d;
    logic                mapped;
    logic                wr_en;
    logic                hit_clk;
    logic                hit_ubh;
    logic                hit_ubl;
    logic                hit_status;
    logic [2:0]          hit_dth;
    logic [2:0]          hit_dtl;
    logic [2:0]          hit_ctl;
    logic [31:0]         status_word;

    // Address decode; the bus never waits, so the access phase is one cycle.
    assign hit_clk    = (paddr == pwm_pkg::OFF_CLOCK_SELECT_PRESCALE);
    assign hit_ubh    = (paddr == pwm_pkg::OFF_UPPER_BOUND_HIGH);
    assign hit_ubl    = (paddr == pwm_pkg::OFF_UPPER_BOUND_LOW);
    assign hit_status = (paddr == pwm_pkg::OFF_STATUS);
    assign mapped     = hit_clk | hit_ubh | hit_ubl | hit_status | (|hit_dth) | (|hit_dtl) | (|hit_ctl);
    assign wr_en      = psel & penable & pwrite & mapped;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;

    // Per-channel decode and register storage.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_chan_regs
            localparam logic [7:0] BASE = 8'(pwm_pkg::OFF_CHAN_BASE + 8'(gi) * pwm_pkg::OFF_CHAN_STRIDE);
            assign hit_dth[gi] = (paddr == BASE);
            assign hit_dtl[gi] = (paddr == 8'(BASE + pwm_pkg::OFF_DUTY_LOW_REL));
            assign hit_ctl[gi] = (paddr == 8'(BASE + pwm_pkg::OFF_CTRL_REL));

            // Duty changes take effect at once; glitch-free updates are left to software timing.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    dth_q[gi] <= pwm_pkg::RST_REG8;
                    dtl_q[gi] <= pwm_pkg::RST_REG8;
                    ctl_q[gi] <= pwm_pkg::RST_REG8;
                end
                else
                begin
                    if (wr_en && hit_dth[gi])
                        dth_q[gi] <= pwdata[7:0];
                    if (wr_en && hit_dtl[gi])
                        dtl_q[gi] <= pwdata[7:0];
                    if (wr_en && hit_ctl[gi])
                        ctl_q[gi] <= pwdata[7:0] & pwm_pkg::CTRL_WR_MASK;
                end
            end
        end
    endgenerate

    // Shared registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_cfg_q <= pwm_pkg::RST_REG8;
            ubh_q     <= pwm_pkg::RST_REG8;
            ubl_q     <= pwm_pkg::RST_REG8;
        end
        else
        begin
            if (wr_en && hit_clk)
                clk_cfg_q <= pwdata[7:0];
            if (wr_en && hit_ubh)
                ubh_q <= pwdata[7:0];
            if (wr_en && hit_ubl)
                ubl_q <= pwdata[7:0];
        end
    end

    // Read multiplexer; unmapped addresses read zero and flag an error.
    always_comb
    begin
        rdata_d = pwm_pkg::RST_RDATA;
        if (hit_clk)
            rdata_d = {24'h0, clk_cfg_q};
        else if (hit_ubh)
            rdata_d = {24'h0, ubh_q};
        else if (hit_ubl)
            rdata_d = {24'h0, ubl_q};
        else if (hit_status)
            rdata_d = status_word;
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (hit_dth[i])
                    rdata_d = {24'h0, dth_q[i]};
                if (hit_dtl[i])
                    rdata_d = {24'h0, dtl_q[i]};
                if (hit_ctl[i])
                    rdata_d = {24'h0, ctl_q[i]};
            end
        end
    end

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= pwm_pkg::RST_RDATA;
        else if (psel && !penable && !pwrite)
            prdata <= rdata_d;
    end

    // ------------------------------------------------------------------
    // Shared time base
    // ------------------------------------------------------------------
    logic       run;
    logic       src_tick;
    logic [2:0] pre_code;
    logic [7:0] pdiv;
    logic [6:0] pre_q;
    logic       pre_last;
    logic       tick;
    logic       phase;
    logic [9:0] cnt_q;
    logic [9:0] cbound;
    logic [10:0] pos;

    assign run      = clk_cfg_q[pwm_pkg::CLK_EN_BIT];
    assign src_tick = clk_cfg_q[pwm_pkg::CLK_SRC_BIT] ? internal_fast_rc_clock : 1'b1;
    assign pre_code = clk_cfg_q[pwm_pkg::CLK_PRE_LSB +: 3];
    assign pdiv     = 8'h01 << pre_code;
    assign pre_last = ({1'b0, pre_q} == 8'(pdiv - 8'h01));
    assign tick     = run & src_tick & pre_last;
    assign cbound   = {ubh_q, ubl_q[pwm_pkg::LOW_DB_LSB +: 2]};
    // The second half of each prescaled step gives the half-step resolution.
    // With a divide of one there is no half step, so the half-step bit has no effect.
    assign phase    = (pre_code != 3'h0) && ({1'b0, pre_q} >= (pdiv >> 1));
    assign pos      = {cnt_q, phase};
    assign status_word = {20'h0, run, cnt_q, phase};

    // Prescaler and common up-counter; stopped and cleared while disabled.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= 7'h00;
            cnt_q <= 10'h000;
        end
        else if (!run)
        begin
            pre_q <= 7'h00;
            cnt_q <= 10'h000;
        end
        else if (src_tick)
        begin
            pre_q <= pre_last ? 7'h00 : 7'(pre_q + 7'h01);
            if (pre_last)
                cnt_q <= (cnt_q >= cbound) ? 10'h000 : 10'(cnt_q + 10'h001);
        end
    end

    // ------------------------------------------------------------------
    // Channel waveforms
    // ------------------------------------------------------------------
    logic [2:0] wave;
    logic [2:0] gated;
    logic [2:0] chan_lvl;
    logic       comb0;
    logic       gate_ok;

    // Each channel compares the shared position against its own duty bound.
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_wave
            logic [10:0] duty;
            assign duty     = {dth_q[gi], dtl_q[gi][pwm_pkg::LOW_DB_LSB +: 2], dtl_q[gi][pwm_pkg::LOW_HALF]};
            assign wave[gi] = run & (pos <= duty);
        end
    endgenerate

    // Channel zero combining logic for complementary outputs with dead zones.
    assign comb0 = (ctl_q[0].comb == pwm_pkg::COMB_OR)  ? (wave[0] | wave[1]) :
                   (ctl_q[0].comb == pwm_pkg::COMB_XOR) ? (wave[0] ^ wave[1]) :
                   wave[0];
    assign gate_ok  = ~comparator_gating_option | comparator_result;
    assign gated    = {wave[2], wave[1], comb0} & {3{gate_ok}};
    assign chan_lvl = gated ^ {ctl_q[2].inv, ctl_q[1].inv, ctl_q[0].inv};

    // ------------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------------
    logic [3:0] pin0;
    logic [3:0] pin1;
    logic [3:0] pin2;
    logic       own0;
    logic       own1;
    logic       own2;
    logic [pwm_pkg::NUM_PINS-1:0] out_d;
    logic [pwm_pkg::NUM_PINS-1:0] oe_d;

    assign pin0 = chan_pin(2'h0, ctl_q[0].pin);
    assign pin1 = chan_pin(2'h1, ctl_q[1].pin);
    assign pin2 = chan_pin(2'h2, ctl_q[2].pin);
    assign own1 = ctl_q[1].en;
    assign own0 = ctl_q[0].en & ~(own1 & (pin1 == pin0));
    assign own2 = ctl_q[2].en & ~(ctl_q[0].en & (pin0 == pin2));

    // Every pin picks its driving channel; the open-drain pin only pulls low.
    generate
        for (gi = 0; gi < pwm_pkg::NUM_PINS; gi++)
        begin : g_pin
            logic h0;
            logic h1;
            logic h2;
            logic lvl;
            assign h0  = own0 & (pin0 == 4'(gi));
            assign h1  = own1 & (pin1 == 4'(gi));
            assign h2  = own2 & (pin2 == 4'(gi));
            assign lvl = h1 ? chan_lvl[1] : (h0 ? chan_lvl[0] : chan_lvl[2]);
            if (4'(gi) == pwm_pkg::PIN_PA5)
            begin : g_od
                assign out_d[gi] = 1'b0;
                assign oe_d[gi]  = h2 & ~lvl;
            end
            else
            begin : g_pp
                assign out_d[gi] = (h0 | h1 | h2) & lvl;
                assign oe_d[gi]  = h0 | h1 | h2;
            end
        end
    endgenerate

    // Registered pins keep routing changes from glitching the outputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= '0;
            pin_oe  <= '0;
        end
        else
        begin
            pin_out <= out_d;
            pin_oe  <= oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && cnt_q >= cbound && !wr_en) |=> (cnt_q == 10'h000))
        else $error("counter did not restart at the bound");

    chk_counter_step: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && cnt_q < cbound && !wr_en) |=> (cnt_q == 10'($past(cnt_q) + 10'h001)))
        else $error("counter did not advance by one");

    chk_prescale_two: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !clk_cfg_q[pwm_pkg::CLK_SRC_BIT] && pre_code == 3'h1 && !wr_en) ##1 !wr_en
        |-> !tick ##1 tick)
        else $error("divide by two prescaler spacing wrong");

    chk_restart_high: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && cnt_q >= cbound && !wr_en) |=> (wave == 3'h7))
        else $error("outputs not high at period restart");

    chk_past_duty_low: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_q > {dth_q[1], dtl_q[1][pwm_pkg::LOW_DB_LSB +: 2]}) |-> !wave[1])
        else $error("channel one high past its duty");

    chk_od_pin: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_out[pwm_pkg::PIN_PA5])
        else $error("open drain pin driven high");

    chk_shared_pb6: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_q[1].en && pin1 == pwm_pkg::PIN_PB6) |=> (pin_out[pwm_pkg::PIN_PB6] == $past(chan_lvl[1])))
        else $error("shared pin not given to channel one");

    chk_shared_pb5: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_q[0].en && pin0 == pwm_pkg::PIN_PB5) |=> (pin_out[pwm_pkg::PIN_PB5] == $past(chan_lvl[0])))
        else $error("shared pin not given to channel zero");

    chk_xor_pair: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_q[0].comb == pwm_pkg::COMB_XOR && gate_ok) |-> (chan_lvl[0] == (wave[0] ^ wave[1] ^ ctl_q[0].inv)))
        else $error("xor combination wrong");

    chk_gate_low: assert property (@(posedge pclk) disable iff (!presetn)
        (comparator_gating_option && !comparator_result) |-> (chan_lvl == {ctl_q[2].inv, ctl_q[1].inv, ctl_q[0].inv}))
        else $error("comparator gating not applied");

    chk_clock_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_clk) |=> (clk_cfg_q == $past(pwdata[7:0])))
        else $error("clock register write lost");

endmodule
`default_nettype wire

// File: tb/pwm_load_model.sv
// Load model on the output pins: resolves the level that external loads see.
`default_nettype none
module pwm_load_model
(
    input  wire logic                         pclk,       // Bench clock.
    input  wire logic [pwm_pkg::NUM_PINS-1:0] pin_out,    // Driven pin levels.
    input  wire logic [pwm_pkg::NUM_PINS-1:0] pin_oe,     // Pin drive enables.
    output logic      [pwm_pkg::NUM_PINS-1:0] pin_level   // Level at the load.
);
    logic [pwm_pkg::NUM_PINS-1:0] last_q;

    // A floating pin shows the inverse of its last level, so a stale value never passes.
    // The open-drain pin has a pull-up, so a released pin reads high.
    always_comb
    begin
        pin_level = (pin_oe & pin_out) | (~pin_oe & ~last_q);
        pin_level[pwm_pkg::PIN_PA5] = ~pin_oe[pwm_pkg::PIN_PA5];
    end

    // Remember the last level for the floating case.
    always_ff @(posedge pclk)
    begin
        last_q <= pin_level;
    end
endmodule
`default_nettype wire

// File: tb/triple_11bit_pwm_generator_tb_top.sv
// Self-checking bench of the triple PWM generator: registers and pin waveforms.
`default_nettype none
module triple_11bit_pwm_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] clk, c0, c1, c2; logic [3:0] gate, pin; logic [7:0] hi, rises;} row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, rc_tick = 1'b0, gate_on = 1'b0, cmp_res = 1'b0;
    logic [12:0] pin_out, pin_oe, lvl;
    int          fail_count = 0, checked = 0, hi, rises, skew, od_bad = 0;
    // Address, write data, expected read back; control bit 3 reads zero, unmapped reads zero.
    logic [23:0] cfg [11] = '{24'h040101, 24'h083f3f, 24'h0c0000, 24'h10a0a0, 24'h180000, 24'h1cdfdf,
                              24'h240000, 24'h280000, 24'h14fff7, 24'h30ff00, 24'h34ff00};
    // Clock reg, three controls, gating, pin, high cycles and rises in 40 cycles (period 10; 20 in the divide-by-four row).
    row_t rows [16] = '{56'h90808080_00_18_04,
                        56'h90808080_05_1c_04,
                        56'h908080c0_08_24_04,
                        56'h90908080_00_1c_04,
                        56'h90a08080_00_04_04,
                        56'h90e08080_00_24_04,
                        56'h90848080_04_18_04,
                        56'h90848180_04_1c_04,
                        56'h90828085_02_18_04,
                        56'h90808085_02_04_04,
                        56'h90808083_0b_04_04,
                        56'h90808080_20_00_00,
                        56'h908080c0_28_28_00,
                        56'h90808080_30_18_04,
                        56'ha0808080_05_1c_02,
                        56'h81808080_05_20_04};

    triple_pwm uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .internal_fast_rc_clock(rc_tick), .comparator_gating_option(gate_on),
        .comparator_result(cmp_res), .pin_out(pin_out), .pin_oe(pin_oe));
    pwm_load_model load (.pclk(pclk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(lvl));

    // ----------------------------------------------------------------
    // Clock, fast RC tick every second cycle, watchdog
    // ----------------------------------------------------------------
    always #4 pclk = ~pclk;
    always @(posedge pclk) rc_tick <= ~rc_tick;
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts high cycles and rising edges of one pin, plus skew between channel zero and one.
    task automatic measure(input logic [3:0] p);
        logic prev, p0, p5;
        repeat (4) @(posedge pclk);
        {prev, p0, p5} = {lvl[p], pin_out[0], pin_out[5]};
        {hi, rises, skew} = {32'h0, 32'h0, 32'h0};
        repeat (40)
        begin
            @(posedge pclk);
            hi += int'(lvl[p] === 1'b1);
            rises += int'(lvl[p] === 1'b1 && prev === 1'b0);
            skew += int'((pin_out[0] & ~p0) !== (pin_out[5] & ~p5));
            od_bad += int'(pin_out[11] !== 1'b0);
            {prev, p0, p5} = {lvl[p], pin_out[0], pin_out[5]};
        end
    endtask

    task automatic close_out();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence: reset, registers, pin table
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge pclk);
        check("oe_in_reset", 32'h0, {19'h00000, pin_oe});
        presetn <= 1'b1;
        for (int a = 0; a <= 48; a += 4)
        begin
            apb(1'b0, 8'(a), 8'h00);
            check("reset_read", pwm_pkg::RST_RDATA, rd);
        end
        // Bounds and duties are written before the counter runs, so no period sees a half update.
        foreach (cfg[i]) apb(1'b1, cfg[i][23:16], cfg[i][15:8]);
        foreach (cfg[i])
        begin
            apb(1'b0, cfg[i][23:16], 8'h00);
            check("readback", {24'h000000, cfg[i][7:0]}, rd);
        end
        apb(1'b0, 8'h34, 8'h00);
        check("slverr", 32'h1, {31'h0, err});
        foreach (rows[i])
        begin
            apb(1'b1, pwm_pkg::OFF_CLOCK_SELECT_PRESCALE, 8'h00);
            apb(1'b1, 8'h14, rows[i].c0);
            apb(1'b1, 8'h20, rows[i].c1);
            apb(1'b1, 8'h2c, rows[i].c2);
            {gate_on, cmp_res} <= rows[i].gate[1:0];
            apb(1'b1, pwm_pkg::OFF_CLOCK_SELECT_PRESCALE, rows[i].clk);
            measure(rows[i].pin);
            check("high_cycles", {24'h000000, rows[i].hi}, hi);
            check("rising_edges", {24'h000000, rows[i].rises}, rises);
            if (rows[i].c0 == 8'h80 && rows[i].c1 == 8'h80)
                check("start_skew", 32'h0, skew);
        end
        check("open_drain_high", 32'h0, od_bad);
        close_out();
    end
endmodule
`default_nettype wire
